// *** design/hub_strap_regs.svh ***
// Constants for the hub strap and shared status pin block.
// Assumes inclusion by bare name from design files only.
`ifndef HUB_STRAP_REGS_SVH
`define HUB_STRAP_REGS_SVH
`define PORT_COUNT        4
`define MODE_I2C          1'h1
`define MODE_SMBUS        1'h0
`define POL_ACTIVE_LOW    1'h0
`define POL_ACTIVE_HIGH   1'h1
`define PWRSW_SUPPORTED   1'h0
`define OVERCUR_ASSERTED  1'h0
`define STRAP_LATCH_TICKS 2'h1
`endif

// *** design/hub_strap_pkg.sv ***
// Types for the hub strap and shared status pin block.
// Assumes no other package.
package hub_strap_pkg;
   typedef enum logic [1:0] {
      ST_RESET,
      ST_SAMPLE,
      ST_RUN
   } strap_state_t;
endpackage : hub_strap_pkg

// *** design/hub_strap_and_status_pins.sv ***
// Strap sampling at reset release and shared pin muxing for the hub.
// Assumes pins arrive synchronous to clk_in; pad logic resolves wire levels from the enables.
// What this block does
// [R1] The mode strap sampled at reset release selects I2C (1) or SMBus (0) for the serial pins.
// [R2] The serial clock pin is driven as EEPROM clock in I2C mode and taken from the host in SMBus mode.
// [R3] The serial data pin talks to the EEPROM in I2C mode and to the SMBus host in SMBus mode.
// [R4] A low port 4 over-current input is an over-current event and a high level is none.
// [R5] The power-switching strap sampled at reset release enables switching and over-current on 0, disables on 1.
// [R6] With full power management, each of the four ports' power is driven through its power control output.
// [R7] In SMBus mode the power-switching strap level serves as slave address bit 1.
// [R8] After reset, when enabled, the power-switching strap pin shows upstream SuperSpeed connection, 1 meaning connected.
// [R9] After reset, when enabled, the mode strap pin shows upstream SuperSpeed suspend, 1 meaning suspended.
// [R10] The polarity strap sampled at reset release makes all power outputs active low (0) or high (1).
// [R11] The board must strap power switching as supported wherever battery charging is used.
// [R12] Each power control output drives its port switch and its level at reset release sets battery charge support.
// [R13] Latched strap values stay unchanged until the next reset even while those pins drive status.
`timescale 1ns/1ns
`include "hub_strap_regs.svh"
module hub_strap_and_status_pins (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       serial_mode_select_in,
   output logic            serial_mode_select_out,
   output logic            serial_mode_select_oe_out,
   input  wire logic       power_switching_strap_n_in,
   output logic            power_switching_strap_n_out,
   output logic            power_switching_strap_n_oe_out,
   input  wire logic       power_control_polarity_in,
   input  wire logic [3:0] port_power_control_in,
   output logic      [3:0] port_power_control_out,
   output logic      [3:0] port_power_control_oe_out,
   input  wire logic       port4_overcurrent_n_in,
   input  wire logic       ss_status_enable_in,
   input  wire logic       ss_connected_in,
   input  wire logic       ss_suspended_in,
   input  wire logic [3:0] port_power_on_in,
   input  wire logic       eeprom_scl_in,
   input  wire logic       eeprom_scl_oe_in,
   input  wire logic       eeprom_sda_out_in,
   input  wire logic       eeprom_sda_oe_in,
   input  wire logic       smbus_sda_oe_in,
   input  wire logic       scl_pin_in,
   output logic            scl_pin_out,
   output logic            scl_pin_oe_out,
   input  wire logic       sda_pin_in,
   output logic            sda_pin_out,
   output logic            sda_pin_oe_out,
   output logic            serial_clock_out,
   output logic            serial_data_out,
   output logic            i2c_mode_out,
   output logic            power_switching_enabled_out,
   output logic            active_high_out,
   output logic            slave_address_bit1_out,
   output logic [3:0]      battery_charge_enable_out,
   output logic            port4_overcurrent_out,
   output logic            straps_valid_out
);
   hub_strap_pkg::strap_state_t state_q;
   logic       mode_q;
   logic       pwrsw_n_q;
   logic       pol_q;
   logic [3:0] batt_q;
   logic       run;

   assign run = (state_q == hub_strap_pkg::ST_RUN);

   // Straps are caught by a clocked process after release; async reset only loads constants
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= hub_strap_pkg::ST_RESET;
      end else begin
         case (state_q)
            hub_strap_pkg::ST_RESET:  state_q <= hub_strap_pkg::ST_SAMPLE;
            hub_strap_pkg::ST_SAMPLE: state_q <= hub_strap_pkg::ST_RUN;
            hub_strap_pkg::ST_RUN:    state_q <= hub_strap_pkg::ST_RUN;
            default:                  state_q <= hub_strap_pkg::ST_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_q    <= `MODE_I2C;
         pwrsw_n_q <= 1'h1;
         pol_q     <= `POL_ACTIVE_HIGH;
         batt_q    <= 4'h0;
      end else if (state_q == hub_strap_pkg::ST_RESET) begin
         // Only this one cycle loads; the pins may turn into outputs later
         mode_q    <= serial_mode_select_in;       // [R1]
         pwrsw_n_q <= power_switching_strap_n_in;  // [R5]
         pol_q     <= power_control_polarity_in;   // [R10]
         batt_q    <= port_power_control_in;       // [R12]
      end
   end
   // [R13] no other assignment to the strap registers exists

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         i2c_mode_out                <= 1'h0;
         power_switching_enabled_out <= 1'h0;
         active_high_out             <= 1'h0;
         slave_address_bit1_out      <= 1'h0;
         battery_charge_enable_out   <= 4'h0;
         straps_valid_out            <= 1'h0;
      end else begin
         i2c_mode_out                <= mode_q == `MODE_I2C;
         power_switching_enabled_out <= pwrsw_n_q == `PWRSW_SUPPORTED;
         active_high_out             <= pol_q;
         // Address bit is the raw strap level, meaningful only in SMBus mode
         slave_address_bit1_out      <= (mode_q == `MODE_SMBUS) ? pwrsw_n_q : 1'h0; // [R7]
         battery_charge_enable_out   <= batt_q;
         straps_valid_out            <= run;
      end
   end

   // Status drive on strap pins only after sampling is done
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         serial_mode_select_out         <= 1'h0;
         serial_mode_select_oe_out      <= 1'h0;
         power_switching_strap_n_out    <= 1'h0;
         power_switching_strap_n_oe_out <= 1'h0;
      end else begin
         power_switching_strap_n_out    <= ss_connected_in;            // [R8]
         power_switching_strap_n_oe_out <= run && ss_status_enable_in; // [R8]
         serial_mode_select_out         <= ss_suspended_in;            // [R9]
         serial_mode_select_oe_out      <= run && ss_status_enable_in; // [R9]
      end
   end

   // Power outputs; off level follows polarity, undriven until straps are held
   genvar gi;
   generate
      for (gi = 0; gi < `PORT_COUNT; gi = gi + 1) begin : g_port
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               port_power_control_out[gi]    <= 1'h0;
               port_power_control_oe_out[gi] <= 1'h0;
            end else begin
               port_power_control_out[gi]    <= (port_power_on_in[gi] && pwrsw_n_q == `PWRSW_SUPPORTED)
                                                ~^ pol_q; // [R6] [R10]
               port_power_control_oe_out[gi] <= run;      // [R6] [R12]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port4_overcurrent_out <= 1'h0;
      end else begin
         // Ignored when switching is strapped off, the pin may float
         port4_overcurrent_out <= run && pwrsw_n_q == `PWRSW_SUPPORTED
                                  && port4_overcurrent_n_in == `OVERCUR_ASSERTED; // [R4] [R5]
      end
   end

   // Serial pin mux: EEPROM master drives clock in I2C mode, host clock is received in SMBus mode
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_pin_out      <= 1'h0;
         scl_pin_oe_out   <= 1'h0;
         sda_pin_out      <= 1'h0;
         sda_pin_oe_out   <= 1'h0;
         serial_clock_out <= 1'h1;
         serial_data_out  <= 1'h1;
      end else begin
         scl_pin_out      <= eeprom_scl_in;                                       // [R2]
         scl_pin_oe_out   <= run && mode_q == `MODE_I2C && eeprom_scl_oe_in;      // [R2]
         sda_pin_out      <= (mode_q == `MODE_I2C) ? eeprom_sda_out_in : 1'h0;    // [R3]
         sda_pin_oe_out   <= run && ((mode_q == `MODE_I2C) ? eeprom_sda_oe_in
                                                           : smbus_sda_oe_in);   // [R3]
         serial_clock_out <= scl_pin_in;                                          // [R2]
         serial_data_out  <= sda_pin_in;                                          // [R3]
      end
   end

   // Strap capture and hold checks
   AST_STRAP_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
      run |=> (mode_q == $past(mode_q) && pwrsw_n_q == $past(pwrsw_n_q) && pol_q == $past(pol_q)))
      else $error("strap changed after sampling");
   AST_MODE_LATCH: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
      state_q == hub_strap_pkg::ST_RESET |=> ##2 i2c_mode_out == $past(serial_mode_select_in, 3))
      else $error("mode strap not latched");
   AST_STATE_SEQ: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
      state_q == hub_strap_pkg::ST_RESET |=> state_q == hub_strap_pkg::ST_SAMPLE)
      else $error("sample state skipped");
   AST_SAMPLE_SEQ: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
      state_q == hub_strap_pkg::ST_SAMPLE |=> run)
      else $error("run state not reached");
   AST_VALID: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
      run |=> straps_valid_out)
      else $error("straps valid missing");
   AST_VALID_EARLY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
      !run |=> !straps_valid_out)
      else $error("straps valid too early");
   AST_I2C_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
      run |=> i2c_mode_out == $past(i2c_mode_out))
      else $error("mode output changed after sampling");
   AST_PSE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
      run |=> power_switching_enabled_out == $past(power_switching_enabled_out))
      else $error("switching output changed after sampling");
   AST_BATT_HOLD_Q: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
      run |=> batt_q == $past(batt_q))
      else $error("battery strap changed after sampling");

   // Serial pin mux checks
   AST_SCL_SMBUS: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
      mode_q == `MODE_SMBUS && run |=> !scl_pin_oe_out)
      else $error("clock driven in SMBus mode");
   AST_SCL_I2C: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
      run && mode_q == `MODE_I2C |=> scl_pin_oe_out == $past(eeprom_scl_oe_in))
      else $error("clock enable wrong in I2C mode");
   AST_SCL_LEVEL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
      1'h1 |=> scl_pin_out == $past(eeprom_scl_in))
      else $error("clock level wrong");
   AST_SCLK_IN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
      1'h1 |=> serial_clock_out == $past(scl_pin_in))
      else $error("received clock wrong");
   AST_PIN_EARLY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
      !run |=> !sda_pin_oe_out && !scl_pin_oe_out)
      else $error("serial pin driven before sampling");
   AST_SDA_SEL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
      run && mode_q == `MODE_SMBUS |=> sda_pin_oe_out == $past(smbus_sda_oe_in))
      else $error("data enable wrong in SMBus mode");
   AST_SDA_I2C: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
      run && mode_q == `MODE_I2C |=> sda_pin_oe_out == $past(eeprom_sda_oe_in))
      else $error("data enable wrong in I2C mode");
   AST_SDA_SMBUS_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
      mode_q == `MODE_SMBUS |=> !sda_pin_out)
      else $error("data level wrong in SMBus mode");
   AST_SDA_LEVEL_I2C: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
      mode_q == `MODE_I2C |=> sda_pin_out == $past(eeprom_sda_out_in))
      else $error("data level wrong in I2C mode");
   AST_SDAT_IN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
      1'h1 |=> serial_data_out == $past(sda_pin_in))
      else $error("received data wrong");

   // Power and over-current checks
   AST_OVERCUR: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
      run && pwrsw_n_q == 1'h0 && !port4_overcurrent_n_in |=> port4_overcurrent_out)
      else $error("over-current missed");
   AST_OVERCUR_NONE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
      port4_overcurrent_n_in |=> !port4_overcurrent_out)
      else $error("over-current without event");
   AST_OVERCUR_EARLY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
      !run |=> !port4_overcurrent_out)
      else $error("over-current before sampling");
   AST_OVERCUR_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
      pwrsw_n_q == 1'h1 |=> !port4_overcurrent_out)
      else $error("over-current with switching off");
   AST_PSE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
      run |-> power_switching_enabled_out == (pwrsw_n_q == `PWRSW_SUPPORTED))
      else $error("switching enable output wrong");
   AST_SW_OFF_POWER: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
      run && pwrsw_n_q == 1'h1 |=> port_power_control_out == {4{~pol_q}})
      else $error("power driven with switching off");
   AST_POWER_POL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R6]
      run && pwrsw_n_q == 1'h0 |=> port_power_control_out[0] == ($past(port_power_on_in[0]) ~^ pol_q))
      else $error("power output polarity wrong");
   AST_POWER_ALL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R6]
      run && pwrsw_n_q == 1'h0 |=> port_power_control_out == ($past(port_power_on_in) ~^ {4{pol_q}}))
      else $error("port power outputs wrong");
   AST_POL_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R10]
      run && !port_power_on_in[1] |=> port_power_control_out[1] == !pol_q)
      else $error("off level wrong");
   AST_POL_ON: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R10]
      run && pwrsw_n_q == 1'h0 && port_power_on_in[2] |=> port_power_control_out[2] == pol_q)
      else $error("on level wrong");
   AST_ACTIVE_HIGH: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R10]
      run |-> active_high_out == pol_q)
      else $error("polarity output wrong");
   AST_POWER_OE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
      run |=> port_power_control_oe_out == 4'hF)
      else $error("power enable not driven");
   AST_POWER_OE_EARLY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
      !run |=> port_power_control_oe_out == 4'h0)
      else $error("power pin driven before sampling");
   AST_BATT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
      run |-> battery_charge_enable_out == batt_q)
      else $error("battery enable lost");
   AST_BATT_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
      run |=> battery_charge_enable_out == $past(battery_charge_enable_out))
      else $error("battery enable changed");

   // Address bit and status drive checks
   AST_ADDR1: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R7]
      run && mode_q == `MODE_SMBUS |=> slave_address_bit1_out == pwrsw_n_q)
      else $error("address bit 1 wrong");
   AST_ADDR1_I2C: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R7]
      mode_q == `MODE_I2C |=> !slave_address_bit1_out)
      else $error("address bit 1 set in I2C mode");
   AST_SS_STATUS: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R8]
      !run |=> !power_switching_strap_n_oe_out && !serial_mode_select_oe_out)
      else $error("strap pin driven before sampling");
   AST_CONN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R8]
      run && ss_status_enable_in |=> power_switching_strap_n_oe_out
                                     && power_switching_strap_n_out == $past(ss_connected_in))
      else $error("connection status wrong");
   AST_CONN_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R8]
      !ss_status_enable_in |=> !power_switching_strap_n_oe_out)
      else $error("connection status driven while disabled");
   AST_SUSP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R9]
      run && ss_status_enable_in |=> serial_mode_select_oe_out && serial_mode_select_out == $past(ss_suspended_in))
      else $error("suspend status wrong");
   AST_SUSP_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R9]
      !ss_status_enable_in |=> !serial_mode_select_oe_out)
      else $error("suspend status driven while disabled");
endmodule : hub_strap_and_status_pins

// *** bench/board_model.sv ***
// Board side of the shared pins: strap resistors, an SMBus host and the port 4 power switch.
// Assumes the bench sets strap levels and host activity; a released pin falls to its strap or pull.
`timescale 1ns/1ns
module board_model (
   input  wire logic strap_mode_in,
   input  wire logic strap_sw_n_in,
   input  wire logic mode_drv_in,
   input  wire logic mode_oe_in,
   input  wire logic sw_drv_in,
   input  wire logic sw_oe_in,
   input  wire logic scl_drv_in,
   input  wire logic scl_oe_in,
   input  wire logic sda_drv_in,
   input  wire logic sda_oe_in,
   input  wire logic host_act_in,
   input  wire logic fault_in,
   output logic      mode_pad_out,
   output logic      sw_pad_out,
   output logic      scl_pad_out,
   output logic      sda_pad_out,
   output logic      oc_n_out
);
   // Strap resistors only show while the hub leaves the pin released
   assign mode_pad_out = mode_oe_in ? mode_drv_in : strap_mode_in;
   assign sw_pad_out   = sw_oe_in ? sw_drv_in : strap_sw_n_in;
   // An idle host leaves both lines to their pull-downs
   assign scl_pad_out  = scl_oe_in ? scl_drv_in : host_act_in;
   assign sda_pad_out  = sda_oe_in ? sda_drv_in : host_act_in;
   assign oc_n_out     = ~fault_in;
endmodule : board_model

// *** bench/tb.sv ***
// Self-checking bench walking four strap setups through reset, strap latch and status drive.
// Assumes board_model resolves the shared pads from the hub's drives and the board.
`timescale 1ns/1ns
module tb;
   logic       clk_in, rst_n_in, sm, sw, sp, ss_en, ss_conn, ss_susp, fault, host;
   logic       mo, moe, so, soe, sclo, scloe, sdao, sdaoe, sclk, sdat, i2c, pse, ah, sa1, oc4, valid;
   logic       mpad, spad, sclpad, sdapad, ocn;
   logic [3:0] sb, pwr_on, pco, pcoe, bat;
   int         n_fail = 0;
   int         comparisons = 0;
   initial begin
      clk_in = 1'h0;
      forever #20 clk_in = ~clk_in;
   end
   hub_strap_and_status_pins i_hub_strap_and_status_pins (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .serial_mode_select_in(mpad), .serial_mode_select_out(mo),
      .serial_mode_select_oe_out(moe), .power_switching_strap_n_in(spad), .power_switching_strap_n_out(so),
      .power_switching_strap_n_oe_out(soe), .power_control_polarity_in(sp), .port_power_control_in(sb),
      .port_power_control_out(pco), .port_power_control_oe_out(pcoe), .port4_overcurrent_n_in(ocn),
      .ss_status_enable_in(ss_en), .ss_connected_in(ss_conn), .ss_suspended_in(ss_susp), .port_power_on_in(pwr_on),
      .eeprom_scl_in(1'h1), .eeprom_scl_oe_in(1'h1), .eeprom_sda_out_in(1'h1), .eeprom_sda_oe_in(1'h1),
      .smbus_sda_oe_in(host), .scl_pin_in(sclpad), .scl_pin_out(sclo), .scl_pin_oe_out(scloe), .sda_pin_in(sdapad),
      .sda_pin_out(sdao), .sda_pin_oe_out(sdaoe), .serial_clock_out(sclk), .serial_data_out(sdat), .i2c_mode_out(i2c),
      .power_switching_enabled_out(pse), .active_high_out(ah), .slave_address_bit1_out(sa1),
      .battery_charge_enable_out(bat), .port4_overcurrent_out(oc4), .straps_valid_out(valid));
   board_model i_board_model (
      .strap_mode_in(sm), .strap_sw_n_in(sw), .mode_drv_in(mo), .mode_oe_in(moe), .sw_drv_in(so), .sw_oe_in(soe),
      .scl_drv_in(sclo), .scl_oe_in(scloe), .sda_drv_in(sdao), .sda_oe_in(sdaoe), .host_act_in(host),
      .fault_in(fault), .mode_pad_out(mpad), .sw_pad_out(spad), .scl_pad_out(sclpad), .sda_pad_out(sdapad),
      .oc_n_out(ocn));
   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   // cfg holds mode strap, switching strap, polarity strap and the four battery straps
   task automatic run(input logic [6:0] cfg);
      logic m, w, p;
      int   k;
      {m, w, p} = cfg[6:4];
      @(posedge clk_in);
      rst_n_in <= 1'h0;
      {sm, sw, sp, sb} <= cfg;
      {ss_en, ss_conn, ss_susp, pwr_on, fault, host} <= {3'h4, 4'h6, 1'h0, ~m};
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'h1;
      for (k = 0; k < 8; k++) begin
         @(negedge clk_in);
         if (valid === 1'h1) break;
         chk("status oe before run", {moe, soe}, 2'h0);
         chk("power oe before run", pcoe, 4'h0);
      end
      chk("strap latency", k[3:0], 4'h3);
      chk("i2c mode", i2c, m);
      chk("switching enabled", pse, !w);
      chk("active high", ah, p);
      chk("address bit1", sa1, !m && w);
      chk("battery enable", bat, cfg[3:0]);
      chk("power oe", pcoe, 4'hF);
      @(posedge clk_in);
      {sm, sw, sp, sb} <= ~cfg;
      {ss_conn, ss_susp, fault} <= {~w, ~m, 1'h1};
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("suspend drive", {moe, mo}, {1'h1, ~m});
      chk("connect drive", {soe, so}, {1'h1, ~w});
      chk("straps held", {i2c, pse, ah, sa1}, {m, ~w, p, ~m & w});
      chk("battery held", bat, cfg[3:0]);
      chk("port power", pco, w ? {4{~p}} : (p ? 4'h6 : 4'h9));
      chk("overcurrent", oc4, !w);
      chk("scl drive", scloe, m);
      chk("sda path", {sdaoe, sdao, sdat, sclk}, {1'h1, m, m, 1'h1});
      // Releasing the status pins lets the flipped strap levels reach the hub again
      @(posedge clk_in);
      fault <= 1'h0;
      ss_en <= 1'h0;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk("overcurrent clear", oc4, 1'h0);
      chk("status released", {moe, soe}, 2'h0);
      chk("straps held released", {i2c, pse, ah, sa1}, {m, ~w, p, ~m & w});
   endtask : run
   initial begin
      rst_n_in = 1'h0;
      {sm, sw, sp, sb, ss_en, ss_conn, ss_susp, pwr_on, fault, host} = '0;
      run(7'h5A);
      run(7'h05);
      run(7'h30);
      run(7'h60);
      tally_and_finish();
   end
   // Four setups take about 84 cycles; this margin only catches a hang
   initial begin
      repeat (2000) @(posedge clk_in);
      n_fail++;
      tally_and_finish();
   end
endmodule : tb
